// ---- motion_params.svh ----
// timing counts, widths and reset values for the sensor-count and position-command block
`ifndef MOTION_PARAMS_SVH
`define MOTION_PARAMS_SVH
`define CLK_HZ          25000000
`define MOD_TIMEOUT_MS  50
`define DIS_BASE_MS     10
`define FILT_CYC        4
`define MAX_SENSORS     16
`define FRAC_SH         16
`define FRAC_ONE        17'h10000
`define RST_POS         24'h000000
`define RST_CNT         5'h00
`endif

// ---- motion_pkg.sv ----
// types shared by the sensor-count and position-command block
package motion_pkg;
  typedef enum logic [2:0] {
    MODE_BIDIR,
    MODE_UNI_SLESS,
    MODE_UNI_HSENS,
    MODE_PWM,
    MODE_FREQ
  } mode_t;

  typedef struct packed {
    mode_t              mode;
    logic               a_rise;      // sensorless start edge: 1 rising, 0 falling
    logic               dir_fixed;   // direction for unidirectional modes
    logic               home_every;  // rehome on every enable
    logic [23:0]        trig_len;    // longest enable low time taken as a pulse, cycles
    logic signed [23:0] pos_lo;      // first limit
    logic signed [23:0] pos_hi;      // second limit
    logic [23:0]        f_min;       // frequency for first limit, Hz
    logic [23:0]        f_max;       // frequency for second limit, Hz
  } cfg_t;
endpackage

// ---- sensor_move_ctrl.sv ----
// multi-sensor move control and pwm or frequency position command decoding
`timescale 1ns/1ns
`default_nettype none
`include "motion_params.svh"

module sensor_move_ctrl
  import motion_pkg::*;
#(
  parameter int unsigned MOD_TO_CYC   = (`CLK_HZ / 1000) * `MOD_TIMEOUT_MS,
  parameter int unsigned DIS_BASE_CYC = (`CLK_HZ / 1000) * `DIS_BASE_MS
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               enable_pin,
  input  wire logic               input_a_pin,
  input  wire logic               input_b_pin,
  input  wire cfg_t               cfg,
  input  wire logic               homing_done,
  input  wire logic signed [23:0] cur_pos,
  output logic                    energize_r,
  output logic                    homing_req_r,
  output logic                    moving_r,
  output logic                    move_dir_r,
  output logic                    alt_speed_r,
  output logic                    stop_pulse_r,
  output logic                    mod_loss_r,
  output logic signed [23:0]      target_pos_r,
  output logic [4:0]              trig_cnt_r,
  output logic [4:0]              sens_cnt_r
);
  localparam int TW = 24;

  // input order: 0 enable, 1 input a, 2 input b
  logic [2:0] raw;
  logic [2:0] s2_r;
  logic [2:0] flt_r;
  logic [2:0] flt_d_r;
  logic [2:0] rise;
  logic [2:0] fall;
  assign raw = {input_b_pin, input_a_pin, enable_pin};

  // two-stage sync then a stability filter per input; each lane owns its flops
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      logic       sa_r;
      logic       sb_r;
      logic       lv_r;
      logic       lv_d_r;
      logic [2:0] fcnt_r;
      always_ff @(posedge clk) begin
        if (reset) begin
          sa_r   <= 1'b0;
          sb_r   <= 1'b0;
          lv_r   <= 1'b0;
          lv_d_r <= 1'b0;
          fcnt_r <= 3'h0;
        end else begin
          sa_r   <= raw[gi];
          sb_r   <= sa_r;
          lv_d_r <= lv_r;
          if (sb_r == lv_r) begin
            fcnt_r <= 3'h0;
          end else if (fcnt_r == 3'(`FILT_CYC - 1)) begin
            fcnt_r <= 3'h0;
            lv_r   <= sb_r;
          end else begin
            fcnt_r <= fcnt_r + 3'h1;
          end
        end
      end
      assign s2_r[gi]    = sb_r;
      assign flt_r[gi]   = lv_r;
      assign flt_d_r[gi] = lv_d_r;
    end
  endgenerate
  assign rise = flt_r & ~flt_d_r;
  assign fall = ~flt_r & flt_d_r;

  // enable low-time measurement, trigger pulse and disable limit
  logic [TW-1:0] en_low_r;
  logic [TW-1:0] dis_lim;
  logic          short_pulse;
  logic          dis_hit;
  assign dis_lim     = cfg.trig_len + TW'(DIS_BASE_CYC);
  assign short_pulse = rise[0] && (en_low_r != '0) && (en_low_r <= cfg.trig_len);
  assign dis_hit     = en_low_r >= dis_lim;

  // mode decode
  logic multi;
  logic pos_mode;
  logic needs_home;
  logic ready;
  assign multi      = (cfg.mode == MODE_BIDIR) || (cfg.mode == MODE_UNI_SLESS)
                    || (cfg.mode == MODE_UNI_HSENS);
  assign pos_mode   = (cfg.mode == MODE_PWM) || (cfg.mode == MODE_FREQ);
  assign needs_home = multi;
  logic homed_r;
  assign ready      = energize_r && (homed_r || !needs_home);

  // start events and direction per mode
  logic a_edge;
  logic start_evt;
  logic start_dir;
  logic sens_evt;
  logic hit;
  logic same_dir;
  logic idle_start;
  logic pend_start;
  logic [4:0] pend_cnt_r;
  logic       pend_dir_r;
  logic       alt_pend_r;
  assign a_edge     = cfg.a_rise ? rise[1] : fall[1];
  assign start_evt  = ready && ((cfg.mode == MODE_UNI_SLESS) ? a_edge
                    : ((cfg.mode == MODE_BIDIR) || (cfg.mode == MODE_UNI_HSENS))
                    && short_pulse);
  assign start_dir  = (cfg.mode == MODE_BIDIR) ? flt_r[1] : cfg.dir_fixed;
  assign sens_evt   = multi && (rise[2] || fall[2]);
  assign hit        = moving_r && energize_r && sens_evt
                    && (sens_cnt_r + 5'h1 == trig_cnt_r);
  assign same_dir   = moving_r && (start_dir == move_dir_r) && (pend_cnt_r == '0);
  assign idle_start = start_evt && !moving_r && (pend_cnt_r == '0);
  assign pend_start = !moving_r && (pend_cnt_r != '0) && energize_r;

  // enable, energize and homing state
  always_ff @(posedge clk) begin
    if (reset) begin
      en_low_r     <= '0;
      energize_r   <= 1'b0;
      homed_r      <= 1'b0;
      homing_req_r <= 1'b0;
    end else begin
      en_low_r     <= flt_r[0] ? '0 : (&en_low_r ? en_low_r : en_low_r + TW'(1));
      if (flt_r[0]) begin
        energize_r <= 1'b1;
      end else if (dis_hit) begin
        energize_r <= 1'b0;
      end
      if (energize_r && homing_done) begin
        homed_r <= 1'b1;
      end else if (!energize_r && cfg.home_every) begin
        homed_r <= 1'b0;
      end
      homing_req_r <= energize_r && needs_home && !homed_r && !homing_done;
    end
  end

  // move sequencing: accumulate, pend opposite direction, stop on count match
  always_ff @(posedge clk) begin
    if (reset || !energize_r) begin
      moving_r     <= 1'b0;
      move_dir_r   <= 1'b0;
      trig_cnt_r   <= `RST_CNT;
      sens_cnt_r   <= `RST_CNT;
      pend_cnt_r   <= `RST_CNT;
      pend_dir_r   <= 1'b0;
      stop_pulse_r <= 1'b0;
      alt_speed_r  <= 1'b0;
      alt_pend_r   <= 1'b0;
    end else begin
      stop_pulse_r <= hit;
      if (cfg.mode == MODE_UNI_SLESS && short_pulse) begin
        alt_pend_r <= 1'b1;
      end else if (idle_start) begin
        alt_pend_r <= 1'b0;
      end
      if (hit) begin
        moving_r   <= 1'b0;
        trig_cnt_r <= `RST_CNT;
        sens_cnt_r <= `RST_CNT;
      end else if (sens_evt && moving_r) begin
        sens_cnt_r <= sens_cnt_r + 5'h1;
      end
      if (idle_start) begin
        moving_r    <= 1'b1;
        trig_cnt_r  <= 5'h01;
        move_dir_r  <= start_dir;
        alt_speed_r <= alt_pend_r;
      end else if (pend_start) begin
        moving_r   <= 1'b1;
        trig_cnt_r <= pend_cnt_r;
        move_dir_r <= pend_dir_r;
        pend_cnt_r <= `RST_CNT;
      end else if (start_evt && same_dir && !hit) begin
        if (trig_cnt_r != 5'(`MAX_SENSORS)) begin
          trig_cnt_r <= trig_cnt_r + 5'h1;
        end
      end else if (start_evt && (moving_r || pend_cnt_r != '0)) begin
        pend_dir_r <= start_dir;
        if (pend_cnt_r != 5'(`MAX_SENSORS)) begin
          pend_cnt_r <= pend_cnt_r + 5'h1;
        end
      end
    end
  end

  // input b period, high time and quiet time measurement
  logic [TW-1:0] per_cnt_r;
  logic [TW-1:0] hi_cnt_r;
  logic [TW-1:0] quiet_r;
  logic [TW-1:0] per_lat_r;
  logic [TW-1:0] hi_lat_r;
  logic          upd_r;
  logic          loss_w;
  assign loss_w = (cfg.mode == MODE_PWM) ? (quiet_r > TW'(MOD_TO_CYC))
                : (quiet_r >= TW'(MOD_TO_CYC));
  always_ff @(posedge clk) begin
    if (reset) begin
      per_cnt_r  <= '0;
      hi_cnt_r   <= '0;
      quiet_r    <= '0;
      per_lat_r  <= '0;
      hi_lat_r   <= '0;
      upd_r      <= 1'b0;
      mod_loss_r <= 1'b0;
    end else begin
      upd_r      <= rise[2];
      mod_loss_r <= pos_mode && loss_w;
      quiet_r    <= (rise[2] || fall[2]) ? '0 : (&quiet_r ? quiet_r : quiet_r + TW'(1));
      if (rise[2]) begin
        per_lat_r <= per_cnt_r;
        hi_lat_r  <= hi_cnt_r;
        per_cnt_r <= TW'(1);
        hi_cnt_r  <= TW'(1);
      end else begin
        per_cnt_r <= &per_cnt_r ? per_cnt_r : per_cnt_r + TW'(1);
        if (flt_r[2] && !(&hi_cnt_r)) begin
          hi_cnt_r <= hi_cnt_r + TW'(1);
        end
      end
    end
  end

  // duty fraction and frequency fraction in sixteen fractional bits
  logic [39:0]        duty_q;
  logic [31:0]        f_hz;
  logic [31:0]        f_num;
  logic [23:0]        f_den;
  logic [47:0]        freq_q;
  logic [16:0]        frac;
  logic signed [24:0] span;
  logic signed [42:0] prod;
  logic signed [24:0] tgt_w;
  assign duty_q = (per_lat_r == '0) ? 40'h0 : {hi_lat_r, 16'h0} / {16'h0, per_lat_r};
  assign f_hz   = (per_lat_r == '0) ? 32'h0 : 32'(`CLK_HZ) / {8'h0, per_lat_r};
  assign f_num  = (f_hz <= {8'h0, cfg.f_min}) ? 32'h0 : f_hz - {8'h0, cfg.f_min};
  assign f_den  = (cfg.f_max > cfg.f_min) ? cfg.f_max - cfg.f_min : 24'h000001;
  assign freq_q = {f_num, 16'h0} / {24'h0, f_den};
  assign frac   = (cfg.mode == MODE_PWM)
                ? ((duty_q >= 40'(`FRAC_ONE)) ? `FRAC_ONE : duty_q[16:0])
                : ((freq_q >= 48'(`FRAC_ONE)) ? `FRAC_ONE : freq_q[16:0]);
  assign span   = {cfg.pos_hi[23], cfg.pos_hi} - {cfg.pos_lo[23], cfg.pos_lo};
  assign prod   = span * $signed({1'b0, frac});
  assign tgt_w  = {cfg.pos_lo[23], cfg.pos_lo} + 25'(prod >>> `FRAC_SH);

  // target: freeze or loss holds present position, else follow the command
  always_ff @(posedge clk) begin
    if (reset) begin
      target_pos_r <= `RST_POS;
    end else if (pos_mode && (flt_r[1] || loss_w)) begin
      target_pos_r <= cur_pos;
    end else if (pos_mode && upd_r && per_lat_r != '0) begin
      target_pos_r <= tgt_w[23:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  energize_on_a: assert property (flt_r[0] |=> energize_r)
    else $error("enable held but windings not energized");
  disable_delay_a: assert property ($fell(energize_r) |-> $past(en_low_r) >= $past(dis_lim))
    else $error("de-energized before disable delay");
  stop_match_a: assert property (hit |=> stop_pulse_r && !moving_r)
    else $error("no stop on sensor count match");
  count_clear_a: assert property (stop_pulse_r |-> trig_cnt_r == 5'h00 && sens_cnt_r == 5'h00)
    else $error("counters not cleared at stop");
  trig_accum_a: assert property (start_evt && same_dir && !hit && trig_cnt_r < 5'h10
    |=> trig_cnt_r == $past(trig_cnt_r) + 5'h1)
    else $error("same-direction trigger not accumulated");
  dir_hold_a: assert property (moving_r && $past(moving_r) |-> $stable(move_dir_r))
    else $error("direction changed during a move");
  home_gate_a: assert property ($rose(moving_r) |-> $past(homed_r))
    else $error("move started before homing");
  mod_loss_a: assert property (pos_mode && quiet_r > TW'(MOD_TO_CYC) |=> mod_loss_r)
    else $error("loss of modulation not flagged");
  freeze_hold_a: assert property (pos_mode && flt_r[1] |=> target_pos_r == $past(cur_pos))
    else $error("target not frozen while input a asserted");
  filter_src_a: assert property ($changed(flt_r[2]) |-> flt_r[2] == $past(s2_r[2]))
    else $error("filtered level not from synchronised input");
endmodule
`default_nettype wire

// ---- pin_ctrl_model.sv ----
// controller model that drives the enable and auxiliary pins
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl_model (
  input  wire logic clk,
  output var logic  enable_pin,
  output var logic  input_a_pin,
  output var logic  input_b_pin
);
  // pins idle and low; called once at time zero so one process drives the pins
  task automatic rest();
    enable_pin  <= 1'b0;
    input_a_pin <= 1'b0;
    input_b_pin <= 1'b0;
  endtask

  // wait whole clock cycles
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // short low pulses on enable; each is long enough to pass the input filter
  task automatic trig(input int n);
    @(posedge clk);
    repeat (n) begin
      enable_pin <= 1'b0;
      idle(6);
      enable_pin <= 1'b1;
      idle(12);
    end
  endtask

  // set the enable and a levels, then let the filter settle
  task automatic set_pins(input logic en, input logic a);
    @(posedge clk);
    enable_pin <= en;
    input_a_pin <= a;
    idle(12);
  endtask

  // one b transition for each sensor passed
  task automatic sensors(input int n);
    @(posedge clk);
    repeat (n) begin
      input_b_pin <= ~input_b_pin;
      idle(10);
    end
  endtask

  // square wave on b: per cycles period, hi cycles high, never quiet for long
  task automatic wave(input int n, input int per, input int hi);
    @(posedge clk);
    repeat (n) begin
      input_b_pin <= 1'b1;
      idle(hi);
      input_b_pin <= 1'b0;
      idle(per - hi);
    end
  endtask
endmodule
`default_nettype wire

// ---- test_sensor_move_ctrl.sv ----
// self-checking testbench for the sensor-count and position-command block
`timescale 1ns/1ns
`default_nettype none
module test_sensor_move_ctrl;
  import motion_pkg::*;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic               homing_done = 1'b0;
  logic signed [23:0] cur_pos = 24'sh000123;
  cfg_t               cfg = '{MODE_BIDIR, 1'b1, 1'b1, 1'b0, 24'h00000a, 24'sh000000,
                              24'sh010000, 24'h030d40, 24'h0493e0};
  wire logic          enable_pin, input_a_pin, input_b_pin;
  logic               energize_r, homing_req_r, moving_r, move_dir_r;
  logic               alt_speed_r, stop_pulse_r, mod_loss_r;
  logic signed [23:0] target_pos_r;
  logic [4:0]         trig_cnt_r, sens_cnt_r;
  int                 failures = 0;
  int                 cmp_count = 0;
  int                 stops = 0;

  // design with shortened timeouts, and the controller model
  sensor_move_ctrl #(.MOD_TO_CYC(200), .DIS_BASE_CYC(50)) dut_u (.clk, .reset, .enable_pin,
    .input_a_pin, .input_b_pin, .cfg, .homing_done, .cur_pos, .energize_r, .homing_req_r,
    .moving_r, .move_dir_r, .alt_speed_r, .stop_pulse_r, .mod_loss_r, .target_pos_r,
    .trig_cnt_r, .sens_cnt_r);
  pin_ctrl_model ctl_u (.clk, .enable_pin, .input_a_pin, .input_b_pin);

  // 25 mhz clock and a tally of stop pulses
  always #20 clk = ~clk;
  always @(posedge clk) if (stop_pulse_r === 1'b1) stops <= stops + 1;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return energize_r;
      1: return moving_r;
      default: return mod_loss_r;
    endcase
  endfunction

  // bounded wait for a status level
  task automatic wait_for(input int w, input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (pick(w) === v) return;
    end
    failures++;
    complete_run();
  endtask

  // main sequence: bidirectional, sensorless, home-to-sensor, pwm, frequency
  initial begin
    ctl_u.rest();
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1 check(24'(energize_r), 24'h000000);
    ctl_u.set_pins(1'b1, 1'b1);
    wait_for(0, 1'b1);
    check(24'(homing_req_r), 24'h000001);
    ctl_u.trig(1);
    #1 check(24'(moving_r), 24'h000000);
    @(posedge clk);
    homing_done <= 1'b1;
    ctl_u.trig(3);
    #1 check(24'(moving_r), 24'h000001);
    check(24'(move_dir_r), 24'h000001);
    check(24'(trig_cnt_r), 24'h000003);
    ctl_u.sensors(2);
    #1 check(24'(sens_cnt_r), 24'h000002);
    check(24'(moving_r), 24'h000001);
    ctl_u.sensors(1);
    #1 check(24'(stops), 24'h000001);
    check(24'(trig_cnt_r), 24'h000000);
    check(24'(sens_cnt_r), 24'h000000);
    ctl_u.trig(1);
    ctl_u.set_pins(1'b1, 1'b0);
    ctl_u.trig(1);
    #1 check(24'(trig_cnt_r), 24'h000001);
    ctl_u.sensors(1);
    wait_for(1, 1'b1);
    check(24'(move_dir_r), 24'h000000);
    ctl_u.sensors(1);
    // enable low 60 cycles: past the 50-cycle base, short of base plus pulse length
    ctl_u.set_pins(1'b0, 1'b0);
    ctl_u.idle(48);
    #1 check(24'(energize_r), 24'h000001);
    wait_for(0, 1'b0);
    check(24'(moving_r), 24'h000000);
    // sensorless mode, rehoming on every enable
    @(posedge clk);
    cfg.home_every <= 1'b1;
    cfg.mode       <= MODE_UNI_SLESS;
    homing_done    <= 1'b0;
    ctl_u.set_pins(1'b1, 1'b0);
    wait_for(0, 1'b1);
    check(24'(homing_req_r), 24'h000001);
    @(posedge clk);
    homing_done <= 1'b1;
    ctl_u.trig(1);
    ctl_u.set_pins(1'b1, 1'b1);
    #1 check(24'(moving_r), 24'h000001);
    check(24'(move_dir_r), 24'h000001);
    check(24'(alt_speed_r), 24'h000001);
    ctl_u.sensors(1);
    #1 check(24'(moving_r), 24'h000000);
    // falling start edge and the other fixed direction
    @(posedge clk);
    cfg.a_rise    <= 1'b0;
    cfg.dir_fixed <= 1'b0;
    ctl_u.set_pins(1'b1, 1'b0);
    #1 check(24'(moving_r), 24'h000001);
    check(24'(move_dir_r), 24'h000000);
    check(24'(alt_speed_r), 24'h000000);
    ctl_u.sensors(1);
    ctl_u.set_pins(1'b1, 1'b1);
    #1 check(24'(moving_r), 24'h000000);
    // home-to-sensor mode: enable pulses merge, long pulses refused
    @(posedge clk);
    cfg.mode <= MODE_UNI_HSENS;
    ctl_u.trig(2);
    #1 check(24'(moving_r), 24'h000001);
    check(24'(trig_cnt_r), 24'h000002);
    check(24'(move_dir_r), 24'h000000);
    ctl_u.sensors(2);
    @(posedge clk);
    cfg.trig_len <= 24'h000004;
    ctl_u.trig(1);
    #1 check(24'(moving_r), 24'h000000);
    check(24'(energize_r), 24'h000001);
    // pwm command, loss of modulation and freeze
    @(posedge clk);
    cfg.trig_len <= 24'h00000a;
    cfg.mode     <= MODE_PWM;
    ctl_u.set_pins(1'b1, 1'b0);
    ctl_u.wave(6, 40, 10);
    #1 check(target_pos_r, 24'h004000);
    ctl_u.idle(300);
    #1 check(24'(mod_loss_r), 24'h000001);
    check(target_pos_r, 24'h000123);
    @(posedge clk);
    cur_pos <= 24'sh000456;
    ctl_u.set_pins(1'b1, 1'b1);
    ctl_u.wave(4, 40, 20);
    #1 check(target_pos_r, 24'h000456);
    check(24'(mod_loss_r), 24'h000000);
    // frequency command between a negative and a positive limit
    @(posedge clk);
    cfg.mode   <= MODE_FREQ;
    cfg.pos_lo <= 24'shffc000;
    cfg.pos_hi <= 24'sh00c000;
    ctl_u.set_pins(1'b1, 1'b0);
    ctl_u.wave(6, 100, 50);
    #1 check(target_pos_r, 24'h004000);
    wait_for(2, 1'b1);
    check(target_pos_r, 24'h000456);
    check(24'(stops), 24'h000006);
    complete_run();
  end
endmodule
`default_nettype wire
